// *** inc/can_mode_pkg.sv ***
// Package with register map, field positions and timing constants.
package can_mode_pkg;

  // ==========================================================================
  // Register offsets (byte addresses, one 32-bit word each).
  localparam logic [7:0] ctl0_off    = 8'h00;
  localparam logic [7:0] ctl1_off    = 8'h04;
  localparam logic [7:0] btr0_off    = 8'h08;
  localparam logic [7:0] btr1_off    = 8'h0c;
  localparam logic [7:0] idac_off    = 8'h10;
  localparam logic [7:0] stat_off    = 8'h14;
  localparam logic [7:0] irq_st_off  = 8'h18;
  localparam logic [7:0] irq_msk_off = 8'h1c;
  localparam logic [7:0] link_off    = 8'h20;
  localparam logic [7:0] cmd_off     = 8'h24;
  localparam logic [7:0] acc_off     = 8'h40;

  // ==========================================================================
  // Field positions.
  localparam int c0_init_request  = 0;
  localparam int c0_sleep_request = 1;
  localparam int c0_wake_enable   = 2;
  localparam int c1_listen        = 4;
  localparam int c1_busoff_sel    = 3;
  localparam int c1_wake_filter   = 2;
  localparam int c1_sleep_ack     = 1;
  localparam int c1_init_ack      = 0;
  localparam int bt_sjw_lsb       = 6;
  localparam int bt_brp_lsb       = 0;
  localparam int bt_brp_w         = 6;

  // Interrupt status bits.
  localparam int ev_init   = 0;
  localparam int ev_sleep  = 1;
  localparam int ev_wake   = 2;
  localparam int ev_rejoin = 3;
  localparam int n_events  = 4;

  // ==========================================================================
  // Reset values.
  localparam logic [7:0] ctl0_rst = 8'h01;
  localparam logic [7:0] ctl1_rst = 8'h11;
  localparam logic [7:0] btr_rst  = 8'h00;

  // ==========================================================================
  // Timing.
  localparam int clk_mhz          = 100;
  localparam int wake_filter_ns   = 2000;
  localparam int wake_filter_cyc  = (wake_filter_ns * clk_mhz + 999) / 1000;
  localparam logic [7:0] idle_bits     = 8'd11;
  localparam logic [7:0] busoff_blocks = 8'd128;
  localparam logic [7:0] ec_busoff     = 8'hff;

  typedef enum logic [1:0]
  {
    st_init   = 2'b00,
    st_sync   = 2'b01,
    st_run    = 2'b11,
    st_sleep  = 2'b10
  } mode_t;

endpackage

// *** hw/quantum_divider.sv ***
// Time-quantum enable divider driven by the prescaler field.
`timescale 1ns/1ns
module quantum_divider
  import can_mode_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clear,
  input  wire logic [bt_brp_w-1:0] prescale,
  output logic                     tq_pulse
);

  typedef struct packed
  {
    logic [bt_brp_w-1:0] cnt;
    logic                tq;
  } div_t;

  div_t st_ff;
  div_t nxt_st;

  // ==========================================================================
  // Divide by prescale plus one.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tq = 1'b0;
    if (clear)
    begin
      nxt_st.cnt = '0;
    end
    else if (st_ff.cnt >= prescale)
    begin
      nxt_st.cnt = '0; // [R11]
      nxt_st.tq = 1'b1;
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign tq_pulse = st_ff.tq;

endmodule

// *** hw/can_mode_ctrl.sv ***
// CAN mode handshake, bus-off recovery, wake-up and bit-timing registers.
//
// Contract
// [R1] Listen-only receives, never sends ack or errors.
// [R2] Listen-only freezes both error counters.
// [R3] Listen-only blocks any transmission start.
// [R4] Bit 3 picks automatic or requested recovery.
// [R5] Bit 2 picks any-dominant or filtered wake.
// [R6] Sleep ack set on sleep entry.
// [R7] Bus activity in sleep clears sleep ack.
// [R8] Init ack set on initialization entry.
// [R9] Config registers writable only in initialization.
// [R10] Jump width code gives 1 to 4 quanta.
// [R11] Prescaler divides clock by field plus one.
// [R12] Init aborts frames; exit waits 11 recessive.
// [R13] Bus-off exit waits 128 idle sequences.
// [R14] Bit time scales with prescaler and segments; here only the prescaler drives tq_enable, btr1 is stored but unused.
// [R15] Acknowledge bits ignore software writes.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ns
module can_mode_ctrl
  import can_mode_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_pin,
  input  wire logic        tx_request,
  input  wire logic        ack_request,
  input  wire logic        error_request,
  input  wire logic        tx_error_inc,
  input  wire logic        rx_error_inc,
  input  wire logic        bit_tick,
  output logic             tx_pin,
  output logic             tx_start,
  output logic             frame_abort,
  output logic             bus_on,
  output logic [1:0]       resync_jump_width,
  output logic             tq_enable,
  output logic             irq
);

  typedef struct packed
  {
    mode_t           mode;
    logic [7:0]      ctl0;
    logic [7:0]      ctl1;
    logic [7:0]      btr0;
    logic [7:0]      btr1;
    logic [7:0]      idac;
    logic [15:0][7:0] acc;
    logic [n_events-1:0] ev;
    logic [n_events-1:0] msk;
    logic [7:0]      tec;
    logic [7:0]      rec;
    logic            busoff;
    logic [7:0]      rec_cnt;
    logic [7:0]      blk_cnt;
    logic [15:0]     wake_cnt;
    logic [1:0]      rx_sync;
    logic [31:0]     rdata;
    logic            ready;
    logic            err;
    logic            tx;
    logic            txs;
    logic            abort;
    logic            on;
    logic            irq;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic   tq;

  quantum_divider u_div
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (st_ff.mode == st_init),
    .prescale (st_ff.btr0[bt_brp_lsb +: bt_brp_w]),
    .tq_pulse (tq)
  );

  // ==========================================================================
  // Next state.
  always_comb
  begin
    logic       init_act;
    logic       acc_ok;
    logic       wr;
    logic       rd;
    logic       rx;
    logic       listen;
    logic       woke;
    logic [7:0] wd;
    logic [3:0] aidx;
    logic [n_events-1:0] set_ev;
    nxt_st = st_ff;
    wd = pwdata[7:0];
    rx = st_ff.rx_sync[1];
    listen = st_ff.ctl1[c1_listen];
    set_ev = '0;
    woke = 1'b0;
    aidx = paddr[5:2];
    init_act = st_ff.ctl0[c0_init_request] & st_ff.ctl1[c1_init_ack]; // [R8]
    acc_ok = psel & penable & ~st_ff.ready;
    wr = acc_ok & pwrite;
    rd = acc_ok & ~pwrite;
    nxt_st.rx_sync = {st_ff.rx_sync[0], rx_pin};
    nxt_st.ready = acc_ok;
    nxt_st.err = 1'b0;
    nxt_st.txs = 1'b0;
    nxt_st.abort = 1'b0;
    nxt_st.tx = 1'b1;

    // ========================================================================
    // Mode machine.
    unique case (st_ff.mode)
      st_init:
      begin
        nxt_st.ctl1[c1_init_ack] = st_ff.ctl0[c0_init_request];
        if (!st_ff.ctl0[c0_init_request])
        begin
          nxt_st.mode = st_sync;
          nxt_st.rec_cnt = '0;
          nxt_st.blk_cnt = '0;
        end
      end
      st_sync:
      begin
        if (bit_tick)
        begin
          if (!rx)
          begin
            nxt_st.rec_cnt = '0;
          end
          else if (st_ff.rec_cnt + 8'd1 >= idle_bits)
          begin
            nxt_st.rec_cnt = '0;
            if (!st_ff.busoff || st_ff.blk_cnt + 8'd1 >= busoff_blocks) // [R13]
            begin
              nxt_st.mode = st_run; // [R12]
              nxt_st.busoff = 1'b0;
              nxt_st.tec = '0;
              nxt_st.rec = '0;
              set_ev[ev_rejoin] = 1'b1;
            end
            else
            begin
              nxt_st.blk_cnt = st_ff.blk_cnt + 8'd1;
            end
          end
          else
          begin
            nxt_st.rec_cnt = st_ff.rec_cnt + 8'd1;
          end
        end
      end
      st_run:
      begin
        if (st_ff.ctl0[c0_sleep_request])
        begin
          nxt_st.mode = st_sleep;
          nxt_st.ctl1[c1_sleep_ack] = 1'b1; // [R6]
          set_ev[ev_sleep] = 1'b1;
        end
        if (!st_ff.busoff)
        begin
          nxt_st.txs = tx_request & ~listen; // [R3]
          nxt_st.tx = ~((ack_request | error_request) & ~listen); // [R1]
          if (!listen) // [R2]
          begin
            nxt_st.tec = st_ff.tec + {7'd0, tx_error_inc};
            nxt_st.rec = st_ff.rec + {7'd0, rx_error_inc};
            if (nxt_st.tec == ec_busoff)
            begin
              nxt_st.busoff = 1'b1;
              nxt_st.rec_cnt = '0;
              nxt_st.blk_cnt = '0;
            end
          end
        end
        else if (!st_ff.ctl1[c1_busoff_sel]) // [R4]
        begin
          nxt_st.mode = st_sync;
        end
      end
      st_sleep:
      begin
        if (!st_ff.ctl0[c0_sleep_request])
        begin
          woke = 1'b1;
        end
        else if (st_ff.ctl0[c0_wake_enable] && !rx)
        begin
          nxt_st.wake_cnt = st_ff.wake_cnt + 16'd1;
          woke = !st_ff.ctl1[c1_wake_filter] // [R5]
            || st_ff.wake_cnt + 16'd1 >= 16'(wake_filter_cyc);
          set_ev[ev_wake] = woke;
        end
        else
        begin
          nxt_st.wake_cnt = '0;
        end
        if (woke)
        begin
          nxt_st.mode = st_run;
          nxt_st.wake_cnt = '0;
          nxt_st.ctl1[c1_sleep_ack] = 1'b0; // [R7]
          nxt_st.ctl0[c0_sleep_request] = 1'b0;
        end
      end
    endcase

    // ========================================================================
    // Register writes.
    if (wr)
    begin
      unique case (paddr)
        ctl0_off:
        begin
          // Requests cannot be dropped before their handshake completes.
          nxt_st.ctl0[c0_wake_enable] = wd[c0_wake_enable];
          if (wd[c0_init_request] || init_act)
          begin
            nxt_st.ctl0[c0_init_request] = wd[c0_init_request];
          end
          if (wd[c0_sleep_request] || st_ff.ctl1[c1_sleep_ack])
          begin
            nxt_st.ctl0[c0_sleep_request] = wd[c0_sleep_request];
          end
        end
        ctl1_off:
        begin
          if (init_act) // [R9]
          begin
            nxt_st.ctl1[7:2] = wd[7:2]; // [R15]
          end
        end
        btr0_off: if (init_act) nxt_st.btr0 = wd; // [R9] [R10] [R14]
        btr1_off: if (init_act) nxt_st.btr1 = wd; // [R9] [R14]
        idac_off: if (init_act) nxt_st.idac = wd; // [R9]
        irq_st_off: nxt_st.ev = st_ff.ev & ~wd[n_events-1:0];
        irq_msk_off: nxt_st.msk = wd[n_events-1:0];
        cmd_off:
        begin
          if (wd[0] && st_ff.busoff && st_ff.mode == st_run)
          begin
            nxt_st.mode = st_sync; // [R4]
          end
        end
        default:
        begin
          if (paddr >= acc_off && paddr[1:0] == 2'b00 && init_act)
          begin
            nxt_st.acc[aidx] = wd; // [R9]
          end
          else if (paddr < acc_off && paddr != stat_off
                   && paddr != link_off)
          begin
            nxt_st.err = 1'b1;
          end
        end
      endcase
    end

    // Entering initialization aborts frames and clears flags.
    if (nxt_st.ctl0[c0_init_request] && st_ff.mode != st_init)
    begin
      nxt_st.mode = st_init; // [R12]
      nxt_st.abort = 1'b1;
      nxt_st.ev = '0;
      nxt_st.msk = '0;
      nxt_st.ctl1[c1_sleep_ack] = 1'b0;
      nxt_st.ctl0[c0_sleep_request] = 1'b0;
      nxt_st.tx = 1'b1;
      nxt_st.txs = 1'b0;
    end
    if (nxt_st.mode == st_init && st_ff.mode != st_init)
    begin
      set_ev[ev_init] = 1'b1;
    end
    // A set in the same cycle as a clear wins.
    nxt_st.ev = nxt_st.ev | set_ev;

    // ========================================================================
    // Read data.
    nxt_st.rdata = '0;
    if (rd)
    begin
      unique case (paddr)
        ctl0_off:    nxt_st.rdata = {24'd0, st_ff.ctl0};
        ctl1_off:    nxt_st.rdata = {24'd0, st_ff.ctl1};
        btr0_off:    nxt_st.rdata = {24'd0, st_ff.btr0};
        btr1_off:    nxt_st.rdata = {24'd0, st_ff.btr1};
        idac_off:    nxt_st.rdata = {24'd0, st_ff.idac};
        stat_off:    nxt_st.rdata = {29'd0, st_ff.busoff, st_ff.mode};
        irq_st_off:  nxt_st.rdata = {28'd0, st_ff.ev};
        irq_msk_off: nxt_st.rdata = {28'd0, st_ff.msk};
        link_off:    nxt_st.rdata = {16'd0, st_ff.rec, st_ff.tec};
        cmd_off:     nxt_st.rdata = '0;
        default:
        begin
          if (paddr >= acc_off && paddr[1:0] == 2'b00)
          begin
            nxt_st.rdata = {24'd0, st_ff.acc[aidx]};
          end
          else
          begin
            nxt_st.err = 1'b1;
          end
        end
      endcase
    end

    nxt_st.on = (nxt_st.mode == st_run) & ~nxt_st.busoff;
    nxt_st.irq = |(nxt_st.ev & nxt_st.msk);
  end

  // ==========================================================================
  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.mode <= st_init;
      st_ff.ctl0 <= ctl0_rst;
      st_ff.ctl1 <= ctl1_rst;
      st_ff.btr0 <= btr_rst;
      st_ff.btr1 <= btr_rst;
      st_ff.rx_sync <= 2'b11;
      st_ff.tx <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs.
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign tx_pin = st_ff.tx;
  assign tx_start = st_ff.txs;
  assign frame_abort = st_ff.abort;
  assign bus_on = st_ff.on;
  assign resync_jump_width = st_ff.btr0[bt_sjw_lsb +: 2]; // [R10]
  assign tq_enable = tq; // [R11]
  assign irq = st_ff.irq;

endmodule

// *** tb/can_mode_chk.sv ***
// Port assertions for the CAN mode control block.
`timescale 1ns/1ns
module can_mode_chk
  import can_mode_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        tx_pin,
  input wire logic        tx_start,
  input wire logic        frame_abort,
  input wire logic        bus_on,
  input wire logic [1:0]  resync_jump_width,
  input wire logic        tq_enable
);
  // ============
  // Shadows.
  // Writes are shadowed only off the bus, which includes initialization, the only mode where configuration is open.
  // Shadows move at the edge that takes the write, as the block does.
  logic       acc;
  logic       listen_ff;
  logic [7:0] btr_ff;
  logic [6:0] gap_ff;
  logic       gap_ok_ff;

  assign acc = psel && penable && !pready && pwrite;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      listen_ff <= ctl1_rst[c1_listen];
      btr_ff    <= btr_rst;
      gap_ff    <= 7'd0;
      gap_ok_ff <= 1'b0;
    end
    else
    begin
      if (acc && !bus_on && paddr == ctl1_off)
        listen_ff <= pwdata[c1_listen];
      if (acc && !bus_on && paddr == btr0_off)
        btr_ff <= pwdata[7:0];
      gap_ff    <= tq_enable ? 7'd1 : gap_ff + 7'd1;
      gap_ok_ff <= bus_on && (tq_enable || (gap_ok_ff && !(psel && pwrite)));
    end

  // ============
  // Assertions.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_wait_state: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_abort_init: assert property (
    acc && paddr == ctl0_off && pwdata[c0_init_request] && bus_on
    |-> ##[0:3] frame_abort)
    else $error("no abort on init");
  a_abort_bus: assert property (frame_abort |-> ##[0:3] !bus_on)
    else $error("bus on after abort");
  a_listen_quiet: assert property (listen_ff |-> tx_pin)
    else $error("dominant in listen");
  a_listen_nostart: assert property (listen_ff |-> !tx_start)
    else $error("start in listen");
  a_jump_width: assert property (resync_jump_width == btr_ff[7:6])
    else $error("jump width wrong");
  a_tq_period: assert property (
    tq_enable && gap_ok_ff |-> gap_ff == 7'(btr_ff[5:0]) + 7'd1)
    else $error("quantum period wrong");
endmodule

bind can_mode_ctrl can_mode_chk u_can_mode_chk (.*);

// *** tb/can_bus_node.sv ***
// Other nodes on the bus: wired-AND line with dominant pulses on demand.
`timescale 1ns/1ns
module can_bus_node
(
  input  wire logic       pclk,
  input  wire logic       tx_pin,
  input  wire logic       go,
  input  wire logic [8:0] hold_len,
  output logic            rx_pin
);
  logic [8:0] left_ff = 9'd0;

  always_ff @(posedge pclk)
    left_ff <= go ? hold_len : left_ff - 9'(left_ff != 9'd0);

  // The line is recessive unless some node pulls it dominant.
  assign rx_pin = tx_pin & (left_ff == 9'd0);
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the CAN mode control block.
`timescale 1ns/1ns
module tb_top
  import can_mode_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic        rx_pin, tx_request, ack_request, error_request, go, irq;
  logic        tx_error_inc, rx_error_inc, bit_tick, tx_pin, tx_start;
  logic        frame_abort, bus_on, tq_enable;
  logic [1:0]  resync_jump_width, tcnt;
  logic [7:0]  paddr;
  logic [8:0]  hold_len;
  logic [31:0] pwdata, prdata, q;
  int          error_cnt, checks, t, aborts, starts, doms;

  can_mode_ctrl u_can_mode_ctrl (.*);
  can_bus_node u_can_bus_node (.pclk(pclk), .tx_pin(tx_pin), .go(go),
    .hold_len(hold_len), .rx_pin(rx_pin));

  initial
  begin
    pclk = 1'b0;
    forever
      #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    tcnt     <= tcnt + 2'd1;
    bit_tick <= tcnt == 2'd3;
    aborts   += int'(frame_abort === 1'b1);
    starts   += int'(tx_start === 1'b1);
    doms     += int'(tx_pin === 1'b0);
  end

  // ============
  // Shared tasks.
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tmo();
    chk("timeout", 32'd0, 32'd1);
    stop_test();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      tmo();
    q = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    for (n = 0; n < 50; n++)
    begin
      apb(1'b0, a, 32'h0);
      if (q[b] === v)
        break;
    end
    chk($sformatf("bit %0d", b), 32'(v), 32'(q[b]));
  endtask

  // Counts bit ticks until bus_on reaches the wanted level.
  task automatic wait_bus(input logic v);
    int n;
    t = 0;
    for (n = 0; n < 9000 && bus_on !== v; n++)
    begin
      @(posedge pclk);
      t += int'(bit_tick === 1'b1);
    end
    if (bus_on !== v)
      tmo();
  endtask

  task automatic pulse(input logic [8:0] n);
    hold_len <= n;
    go       <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
  endtask

  // ============
  // Scenarios.
  task automatic t_config();
    rd(ctl1_off, 32'(ctl1_rst));
    wr(btr0_off, 32'hc3);
    rd(btr0_off, 32'hc3);
    chk("jump width", 32'd3, 32'(resync_jump_width));
    wr(ctl1_off, 32'h0e);
    rd(ctl1_off, 32'h0d);
  endtask

  task automatic t_leave();
    int a;
    wr(ctl0_off, 32'h0);
    wait_bus(1'b1);
    chk("idle bits", 32'd1, 32'(t >= 10));
    rd(ctl1_off, 32'h0c);
    for (a = 0; a < 100 && tq_enable !== 1'b1; a++)
      @(posedge pclk);
    a = 0;
    do
    begin
      @(posedge pclk);
      a++;
    end
    while (tq_enable !== 1'b1 && a < 100);
    chk("tq period", 32'd4, 32'(a));
    wr(btr0_off, 32'h01);
    rd(btr0_off, 32'hc3);
    wr(ctl1_off, 32'h10);
    rd(ctl1_off, 32'h0c);
  endtask

  task automatic t_run();
    int s, d;
    s = starts;
    d = doms;
    rx_error_inc <= 1'b1;
    @(posedge pclk);
    rx_error_inc <= 1'b0;
    rd(link_off, 32'h100);
    {tx_request, ack_request} <= 2'b11;
    cyc(8);
    {tx_request, ack_request} <= 2'b00;
    cyc(2);
    chk("tx start", 32'd1, 32'(starts > s));
    chk("ack sent", 32'd1, 32'(doms > d));
    apb(1'b0, 8'h30, 32'h0);
    chk("slave error", 32'd1, 32'(se));
  endtask

  task automatic t_busoff();
    tx_error_inc <= 1'b1;
    cyc(300);
    tx_error_inc <= 1'b0;
    wait_bus(1'b0);
    cyc(6400);
    chk("held off", 32'd0, 32'(bus_on));
    rd(stat_off, 32'h7);
    wr(cmd_off, 32'h1);
    rd(stat_off, 32'h5);
    wr(ctl0_off, 32'h1);
    poll(ctl1_off, c1_init_ack, 1'b1);
    rd(stat_off, 32'h4);
    wr(ctl0_off, 32'h0);
    wait_bus(1'b1);
    chk("rejoin bits", 32'd1, 32'(t >= 11 * 128 - 2));
  endtask

  task automatic t_listen();
    int s, d;
    logic [31:0] c;
    d = aborts;
    wr(ctl0_off, 32'h1);
    poll(ctl1_off, c1_init_ack, 1'b1);
    chk("aborts", 32'd1, 32'(aborts - d));
    wr(ctl1_off, 32'h1c);
    wr(ctl0_off, 32'h0);
    wait_bus(1'b1);
    apb(1'b0, link_off, 32'h0);
    c = q;
    s = starts;
    d = doms;
    {tx_request, ack_request, error_request} <= 3'b111;
    {tx_error_inc, rx_error_inc} <= 2'b11;
    cyc(40);
    {tx_request, ack_request, error_request} <= 3'b000;
    {tx_error_inc, rx_error_inc} <= 2'b00;
    rd(link_off, c);
    chk("starts", 32'(s), 32'(starts));
    chk("dominant", 32'(d), 32'(doms));
  endtask

  task automatic t_sleep();
    wr(irq_msk_off, 32'h0);
    wr(ctl0_off, 32'h6);
    poll(ctl1_off, c1_sleep_ack, 1'b1);
    chk("irq masked", 32'd0, 32'(irq));
    wr(irq_msk_off, 32'h2);
    cyc(2);
    chk("irq raised", 32'd1, 32'(irq));
    wr(irq_st_off, 32'h2);
    cyc(2);
    chk("irq cleared", 32'd0, 32'(irq));
    pulse(9'd100);
    cyc(400);
    rd(ctl1_off, 32'h1e);
    pulse(9'd300);
    cyc(400);
    poll(ctl1_off, c1_sleep_ack, 1'b0);
  endtask

  // Unfiltered wake: a short dominant pulse is enough.
  task automatic t_wake_any();
    wr(ctl0_off, 32'h1);
    poll(ctl1_off, c1_init_ack, 1'b1);
    wr(ctl1_off, 32'h10);
    wr(ctl0_off, 32'h0);
    wait_bus(1'b1);
    wr(ctl0_off, 32'h6);
    poll(ctl1_off, c1_sleep_ack, 1'b1);
    pulse(9'd4);
    cyc(20);
    rd(ctl1_off, 32'h10);
  endtask

  initial
  begin
    {psel, penable, pwrite, tx_request, ack_request, error_request} = '0;
    {tx_error_inc, rx_error_inc, go, tcnt, bit_tick} = '0;
    {paddr, pwdata, hold_len} = '0;
    {error_cnt, checks, aborts, starts, doms} = '0;
    presetn = 1'b0;
    cyc(16);
    presetn <= 1'b1;
    @(posedge pclk);
    t_config();
    t_leave();
    t_run();
    t_busoff();
    t_listen();
    t_sleep();
    t_wake_any();
    stop_test();
  end
endmodule
